// ===== src/ris_pkg.sv
// Purpose: constants for the remappable input selector
// Assumes: 16-bit register port, selector fields 8 bits wide
// Notes: register offsets are word indices on the plain register port
package ris_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int RIS_ADDR_W = 4;
    localparam int RIS_DATA_W = 16;
    localparam int RIS_SEL_W = 8;
    localparam int RIS_PIN_N = 182;  // pins 0..181, pin 0 unused (ground code)
    localparam int RIS_SRC_N = 15;   // number of served peripheral inputs

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] RIS_OFS_EXT_IRQ1 = 4'h0;
    localparam logic [3:0] RIS_OFS_EXT_IRQ2 = 4'h1;
    localparam logic [3:0] RIS_OFS_TIMER_A = 4'h2;
    localparam logic [3:0] RIS_OFS_TIMER_BC = 4'h3;
    localparam logic [3:0] RIS_OFS_CAPTURE = 4'h4;
    localparam logic [3:0] RIS_OFS_CMP_FAULT = 4'h5;
    localparam logic [3:0] RIS_OFS_PWM_FAULT_A = 4'h6;
    localparam logic [3:0] RIS_OFS_PWM_FAULT_B = 4'h7;
    localparam logic [3:0] RIS_OFS_SERIAL = 4'h8;
    localparam logic [3:0] RIS_OFS_SPI = 4'h9;

    // ************************************************************
    // field positions (low bit of each byte field)
    // ************************************************************
    localparam int RIS_FLD_HI = 8;
    localparam int RIS_FLD_LO = 0;

    // ************************************************************
    // codes and reset value
    // ************************************************************
    localparam logic [7:0] RIS_SEL_RST = 8'h00;
    localparam logic [7:0] RIS_SEL_GND = 8'h00;
    localparam logic [7:0] RIS_SEL_MAX = 8'hb5;  // pin 181
    localparam logic [15:0] RIS_RD_IDLE = 16'h0000;

    // source index order of the selector bank
    typedef enum logic [3:0] {
        RIS_S_IRQ1 = 4'h0, RIS_S_IRQ2 = 4'h1, RIS_S_TMA = 4'h2, RIS_S_TMB = 4'h3,
        RIS_S_TMC = 4'h4, RIS_S_CAP = 4'h5, RIS_S_CFLT = 4'h6, RIS_S_PFA = 4'h7,
        RIS_S_PFB = 4'h8, RIS_S_PFC = 4'h9, RIS_S_PFD = 4'ha, RIS_S_CTS = 4'hb,
        RIS_S_RX = 4'hc, RIS_S_SCK = 4'hd, RIS_S_SDI = 4'he
    } ris_src_t;

    // all state of the selector block
    typedef struct packed {
        logic [RIS_SRC_N-1:0][RIS_SEL_W-1:0] sel;
        logic [RIS_DATA_W-1:0] rdata;
        logic [RIS_PIN_N-1:0] pin_s1;
        logic [RIS_PIN_N-1:0] pin_s2;
        logic [RIS_SRC_N-1:0] out;
    } ris_state_t;

endpackage : ris_pkg

// ===== src/ris_selector.sv
// Purpose: remappable input selector, routes package pins to peripheral inputs
// Assumes: one clock, synchronous active-low reset, pins asynchronous to the clock
// Notes: pin inputs pass two flip-flops, then the routed level is registered
//
// Notes on behaviour
// - 8-bit field, value n picks pin n
// - code zero drives input from ground
// - codes b4 and b5 pick pins 180, 181
// - unused register bits read as zero
// - fields read/write, cleared at reset
// - irq one selector in bits 15..8
// - irq two selector in bits 7..0
// - timer a clock selector bits 15..8
// - timer c high byte, timer b low
// - capture selector in bits 7..0
// - compare fault selector in bits 7..0
// - pwm fault b high, fault a low
// - pwm fault d high, fault c low
// - cts high byte, receive low byte
// - spi clock selector in bits 15..8
// - spi data selector in bits 7..0
module ris_selector (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ris_pkg::RIS_ADDR_W-1:0] i_addr,
    input wire logic [ris_pkg::RIS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ris_pkg::RIS_DATA_W-1:0] o_rdata,
    input wire logic [ris_pkg::RIS_PIN_N-1:0] i_remappable_pin,
    output logic o_external_irq_one,
    output logic o_external_irq_two,
    output logic o_timer_a_ext_clock,
    output logic o_timer_b_ext_clock,
    output logic o_timer_c_ext_clock,
    output logic o_capture_channel,
    output logic o_compare_fault,
    output logic o_pwm_fault_a,
    output logic o_pwm_fault_b,
    output logic o_pwm_fault_c,
    output logic o_pwm_fault_d,
    output logic o_serial_clear_to_send,
    output logic o_serial_receive,
    output logic o_spi_clock_line,
    output logic o_spi_data_in_line
);
    import ris_pkg::*;

    ris_state_t st_r;
    ris_state_t st_nxt;

    // ************************************************************
    // register read view
    // ************************************************************

    // pack a register word from a high and a low field
    function automatic logic [RIS_DATA_W-1:0] pack_word(
        input logic [RIS_SEL_W-1:0] hi,
        input logic [RIS_SEL_W-1:0] lo
    );
        pack_word = {hi, lo};
    endfunction

    // unimplemented bytes are packed as constant zero
    function automatic logic [RIS_DATA_W-1:0] read_word(
        input logic [RIS_ADDR_W-1:0] addr,
        input logic [RIS_SRC_N-1:0][RIS_SEL_W-1:0] sel
    );
        case (addr)
            RIS_OFS_EXT_IRQ1: read_word = pack_word(sel[RIS_S_IRQ1], 8'h00);
            RIS_OFS_EXT_IRQ2: read_word = pack_word(8'h00, sel[RIS_S_IRQ2]);
            RIS_OFS_TIMER_A: read_word = pack_word(sel[RIS_S_TMA], 8'h00);
            RIS_OFS_TIMER_BC: read_word = pack_word(sel[RIS_S_TMC], sel[RIS_S_TMB]);
            RIS_OFS_CAPTURE: read_word = pack_word(8'h00, sel[RIS_S_CAP]);
            RIS_OFS_CMP_FAULT: read_word = pack_word(8'h00, sel[RIS_S_CFLT]);
            RIS_OFS_PWM_FAULT_A: read_word = pack_word(sel[RIS_S_PFB], sel[RIS_S_PFA]);
            RIS_OFS_PWM_FAULT_B: read_word = pack_word(sel[RIS_S_PFD], sel[RIS_S_PFC]);
            RIS_OFS_SERIAL: read_word = pack_word(sel[RIS_S_CTS], sel[RIS_S_RX]);
            RIS_OFS_SPI: read_word = pack_word(sel[RIS_S_SCK], sel[RIS_S_SDI]);
            default: read_word = RIS_RD_IDLE; // unmapped offsets read zero
        endcase
    endfunction

    // ************************************************************
    // pin routing
    // ************************************************************

    // ground for code zero and any code past the last pin
    function automatic logic route_pin(
        input logic [RIS_SEL_W-1:0] code,
        input logic [RIS_PIN_N-1:0] pins
    );
        if (code == RIS_SEL_GND) begin
            route_pin = 1'b0;
        end else if (code > RIS_SEL_MAX) begin
            route_pin = 1'b0;
        end else begin
            route_pin = pins[code];
        end
    endfunction

    // ************************************************************
    // next state
    // ************************************************************

    // writes land in the field only for implemented bytes
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = i_remappable_pin;
        st_nxt.pin_s2 = st_r.pin_s1;
        if (i_wr) begin
            case (i_addr)
                RIS_OFS_EXT_IRQ1: st_nxt.sel[RIS_S_IRQ1] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                RIS_OFS_EXT_IRQ2: st_nxt.sel[RIS_S_IRQ2] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                RIS_OFS_TIMER_A: st_nxt.sel[RIS_S_TMA] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                RIS_OFS_TIMER_BC: begin
                    st_nxt.sel[RIS_S_TMC] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                    st_nxt.sel[RIS_S_TMB] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                end
                RIS_OFS_CAPTURE: st_nxt.sel[RIS_S_CAP] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                RIS_OFS_CMP_FAULT: st_nxt.sel[RIS_S_CFLT] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                RIS_OFS_PWM_FAULT_A: begin
                    st_nxt.sel[RIS_S_PFB] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                    st_nxt.sel[RIS_S_PFA] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                end
                RIS_OFS_PWM_FAULT_B: begin
                    st_nxt.sel[RIS_S_PFD] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                    st_nxt.sel[RIS_S_PFC] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                end
                RIS_OFS_SERIAL: begin
                    st_nxt.sel[RIS_S_CTS] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                    st_nxt.sel[RIS_S_RX] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                end
                RIS_OFS_SPI: begin
                    st_nxt.sel[RIS_S_SCK] = i_wdata[RIS_FLD_HI +: RIS_SEL_W];
                    st_nxt.sel[RIS_S_SDI] = i_wdata[RIS_FLD_LO +: RIS_SEL_W];
                end
                default: st_nxt.sel = st_r.sel; // unmapped writes are dropped
            endcase
        end
        // read data stands only in the cycle after the strobe
        st_nxt.rdata = i_rd ? read_word(i_addr, st_r.sel) : RIS_RD_IDLE;
        // routing uses the stored selector, so a write acts one cycle later
        for (int k = 0; k < RIS_SRC_N; k++) begin
            st_nxt.out[k] = route_pin(st_r.sel[k], st_r.pin_s2);
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // every field starts at the ground code
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_r.sel <= {RIS_SRC_N{RIS_SEL_RST}};
            st_r.rdata <= RIS_RD_IDLE;
            st_r.pin_s1 <= '0;
            st_r.pin_s2 <= '0;
            st_r.out <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_rdata = st_r.rdata;
    assign o_external_irq_one = st_r.out[RIS_S_IRQ1];
    assign o_external_irq_two = st_r.out[RIS_S_IRQ2];
    assign o_timer_a_ext_clock = st_r.out[RIS_S_TMA];
    assign o_timer_b_ext_clock = st_r.out[RIS_S_TMB];
    assign o_timer_c_ext_clock = st_r.out[RIS_S_TMC];
    assign o_capture_channel = st_r.out[RIS_S_CAP];
    assign o_compare_fault = st_r.out[RIS_S_CFLT];
    assign o_pwm_fault_a = st_r.out[RIS_S_PFA];
    assign o_pwm_fault_b = st_r.out[RIS_S_PFB];
    assign o_pwm_fault_c = st_r.out[RIS_S_PFC];
    assign o_pwm_fault_d = st_r.out[RIS_S_PFD];
    assign o_serial_clear_to_send = st_r.out[RIS_S_CTS];
    assign o_serial_receive = st_r.out[RIS_S_RX];
    assign o_spi_clock_line = st_r.out[RIS_S_SCK];
    assign o_spi_data_in_line = st_r.out[RIS_S_SDI];

endmodule // ris_selector

// ===== bench/ris_sel_assertions.sv
// Purpose: port checks for the remappable input selector
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every selector instance below
module ris_sel_assertions (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic o_external_irq_one,
    input wire logic o_spi_data_in_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // read port and routing
    // ****************
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    chk_rd_idle_zero: assert property (!i_rd |=> o_rdata == 16'h0)
        else $error("read data not idle");
    chk_irq1_low_zero: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[7:0] == 8'h0)
        else $error("irq one low byte set");
    chk_irq2_high_zero: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[15:8] == 8'h0)
        else $error("irq two high byte set");
    chk_tma_low_zero: assert property (i_rd && i_addr == 4'h2 |=> o_rdata[7:0] == 8'h0)
        else $error("timer a low byte set");
    chk_cap_high_zero: assert property (i_rd && i_addr == 4'h4 |=> o_rdata[15:8] == 8'h0)
        else $error("capture high byte set");
    chk_cflt_high_zero: assert property (i_rd && i_addr == 4'h5 |=> o_rdata[15:8] == 8'h0)
        else $error("compare fault high byte set");
    chk_unmapped_zero: assert property (i_rd && i_addr > 4'h9 |=> o_rdata == 16'h0)
        else $error("unmapped read not zero");
    chk_spi_readback: assert property (
        i_wr && i_addr == 4'h9 ##1 i_rd && i_addr == 4'h9 |=> o_rdata == $past(i_wdata, 2))
        else $error("spi selector readback wrong");
    chk_irq1_ground: assert property (
        i_wr && i_addr == 4'h0 && (i_wdata[15:8] == 8'h0 || i_wdata[15:8] > 8'hb5)
        ##1 !(i_wr && i_addr == 4'h0) |=> !o_external_irq_one)
        else $error("irq one not grounded");
    chk_sdi_ground: assert property (
        i_wr && i_addr == 4'h9 && i_wdata[7:0] == 8'h0
        ##1 !(i_wr && i_addr == 4'h9) |=> !o_spi_data_in_line)
        else $error("spi data not grounded");
    cov_spi_write: cover property (i_wr && i_addr == 4'h9);
    cov_unmapped_read: cover property (i_rd && i_addr == 4'ha);
    cov_irq1_high: cover property (o_external_irq_one);
endmodule // ris_sel_assertions

bind ris_selector ris_sel_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_external_irq_one(o_external_irq_one), .o_spi_data_in_line(o_spi_data_in_line));

// ===== bench/ris_pin_model.sv
// Purpose: package pins seen by the selector
// Assumes: mode 0 all low, 1 all high, 2 one pin high
// Notes: levels move 3 ns after a rising edge of i_clk, the design clock in the bench
module ris_pin_model (
    input wire logic i_clk,
    input wire logic [1:0] i_mode,
    input wire logic [7:0] i_idx,
    output logic [181:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // defined from time zero so the syncs never start unknown
    initial o_pins = '0;
    always @(posedge i_clk) begin
        o_pins <= #3 (i_mode == 2'h1) ? '1 : (i_mode == 2'h2) ? (182'h1 << i_idx) : '0;
    end
endmodule // ris_pin_model

// ===== bench/ris_selector_tb.sv
// Purpose: self-checking bench for the input selector
// Assumes: pins come from the pin model
// Notes: reset readback of offsets 0 to 10 first, then table rows, then hand-written cases
module ris_selector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] mode = 2'h1;
    logic [7:0] idx = 8'h0;
    logic [15:0] o_rdata;
    logic [15:0] d;
    logic [181:0] pins;
    wire logic [14:0] out_v;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    // address, write data, expected readback
    logic [35:0] rows [11] = '{36'h0_ffff_ff00, 36'h1_ffff_00ff, 36'h2_b4b5_b400,
        36'h3_b5b4_b5b4, 36'h4_1234_0034, 36'h5_ab01_0001, 36'h6_0102_0102,
        36'h7_0304_0304, 36'h8_0506_0506, 36'h9_0708_0708, 36'ha_ffff_0000};
    ris_pin_model u_pins (.i_clk(i_clk_sys), .i_mode(mode), .i_idx(idx), .o_pins(pins));
    ris_selector dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_remappable_pin(pins),
        .o_external_irq_one(out_v[14]), .o_external_irq_two(out_v[13]),
        .o_timer_a_ext_clock(out_v[12]), .o_timer_b_ext_clock(out_v[11]),
        .o_timer_c_ext_clock(out_v[10]), .o_capture_channel(out_v[9]),
        .o_compare_fault(out_v[8]), .o_pwm_fault_a(out_v[7]), .o_pwm_fault_b(out_v[6]),
        .o_pwm_fault_c(out_v[5]), .o_pwm_fault_d(out_v[4]),
        .o_serial_clear_to_send(out_v[3]), .o_serial_receive(out_v[2]),
        .o_spi_clock_line(out_v[1]), .o_spi_data_in_line(out_v[0]));
    always #10 i_clk_sys = ~i_clk_sys;
    // ****************
    // bus tasks, all entered just after a rising edge
    // ****************
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= w;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [3:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk_sys);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hang costs at most this many cycles
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        for (int a = 0; a < 11; a++) begin
            rd(4'(a));
            chk(d, 16'h0);
        end
        chk({1'b0, out_v}, 16'h0);
        foreach (rows[i]) begin
            wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32]);
            chk(d, rows[i][15:0]);
        end
        repeat (4) @(posedge i_clk_sys);
        chk({1'b0, out_v}, 16'h1fff);
        mode <= 2'h2;
        idx <= 8'd180;
        repeat (5) @(posedge i_clk_sys);
        chk({1'b0, out_v}, 16'h1800);
        idx <= 8'd181;
        repeat (5) @(posedge i_clk_sys);
        chk({1'b0, out_v}, 16'h0400);
        // a lone mid-range pin catches an off-by-one in the pin index
        idx <= 8'd52;
        repeat (5) @(posedge i_clk_sys);
        chk({1'b0, out_v}, 16'h0200);
        idx <= 8'd1;
        repeat (5) @(posedge i_clk_sys);
        chk({1'b0, out_v}, 16'h0140);
        mode <= 2'h1;
        repeat (5) @(posedge i_clk_sys);
        wr(4'h0, 16'h0100);
        #1 chk({15'h0, out_v[14]}, 16'h0);
        @(posedge i_clk_sys);
        #1 chk({15'h0, out_v[14]}, 16'h1);
        @(posedge i_clk_sys);
        wr(4'h9, 16'hb400);
        rd(4'h9);
        chk(d, 16'hb400);
        chk({1'b0, out_v}, 16'h5ffe);
        // let the grounding checks finish before reset disables them
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        rd(4'h9);
        chk(d, 16'h0);
        chk({1'b0, out_v}, 16'h0);
        wrap_up();
    end
endmodule // ris_selector_tb
